// File: core/adcsq_cfg.svh
// Constants for the converter sequencer control
`ifndef ADCSQ_CFG_SVH
`define ADCSQ_CFG_SVH
`define ADCSQ_START_STOP 2'h0
`define ADCSQ_START_IMM 2'h1
`define ADCSQ_START_EDGE 2'h2
`define ADCSQ_START_DUAL 2'h3
`define ADCSQ_MODE_STEP 3'h0
`define ADCSQ_MODE_SINGLE 3'h1
`define ADCSQ_MODE_CONT 3'h2
`define ADCSQ_MODE_SCANC 3'h3
`define ADCSQ_MSB_POS 4
`define ADCSQ_SLOT_LAST 2'h3
`endif

// File: core/adcsq_pkg.sv
// Types for the converter sequencer control
package adcsq_pkg;
  typedef struct packed {
    logic enable;
    logic [2:0] mode;
    logic [1:0] start_mode;
    logic timer_sel;
    logic edge_pol;
    logic done_irq_en;
    logic bnd_irq_en;
    logic [3:0] input_sel;
  } adcsq_cfg_t;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } adcsq_lim_t;
  typedef enum logic [2:0] {
    ADCSQ_IDLE = 3'b001,
    ADCSQ_CONV = 3'b010,
    ADCSQ_WAIT = 3'b100
  } adcsq_state_t;
endpackage

// File: core/adcsq_top.sv
// Sequencer control for two four-input successive approximation converters
// Function
// - Fixed single: convert once, store, stop, flag
// - Single and scan modes: input n to result n
// - Fixed continuous fills results zero..three cyclically
// - Fixed continuous flags once per four conversions
// - Scan selected inputs lowest to highest
// - Scan single: each once, flag, stop
// - Scan continuous restarts at first selected input
// - Dual: first to 0,2; second to 1,3
// - Dual flags after each four conversions
// - Single step: one input per start, flag
// - Mode bits decode to four mode patterns
// - Timer overflow starts; overflows ignored while busy
// - Immediate start encoding starts at once
// - Chosen pin edge starts; edges ignored while busy
// - Dual encoding on either starts both together
// - Each converter has high and low limits
// - Early upper-nibble compare raises boundary flag
// - Inside early check: compare full result too
// - Boundary enable cleared suppresses boundary flag
// - Start bits: timer/stop, immediate, edge, dual
// - Polarity zero falling edge, one rising
// - Done flag set by hardware, cleared by software
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_cfg.svh"
module adcsq_unit
  import adcsq_pkg::*;
#(
  parameter int RES_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire adcsq_cfg_t cfg,
  input wire adcsq_lim_t lim,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic done_clr,
  input wire logic bnd_clr,
  input wire logic sar_msb_valid,
  input wire logic sar_done,
  input wire logic [RES_W-1:0] sar_result,
  output logic sar_start,
  output logic [1:0] sar_chan,
  output logic busy,
  output logic done_flag,
  output logic bnd_flag,
  output logic [4*RES_W-1:0] results
);
  adcsq_state_t state_q;
  logic [1:0] chan_q;
  logic [1:0] slot_q;
  logic [1:0] first_q;
  logic run_q;
  logic cont_q;
  logic early_in_q;
  logic [2:0] nsel;
  logic [1:0] first_sel;
  logic [1:0] next_sel;
  logic has_next;
  logic is_dual;
  logic is_fixed_cont;
  logic [1:0] store_slot;
  logic group_end;
  logic keep_on;
  logic busy_q;
  logic early_out;
  logic full_out;
  logic bnd_set;
  always_comb begin
    nsel = 3'h0;
    first_sel = 2'h0;
    next_sel = 2'h0;
    has_next = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      if (cfg.input_sel[i]) begin
        first_sel = 2'(i);
      end
    end
    for (int i = 0; i < 4; i++) begin
      nsel = nsel + 3'(cfg.input_sel[i]);
    end
    for (int i = 3; i >= 0; i--) begin
      if (cfg.input_sel[i] && 2'(i) > chan_q && !(chan_q == 2'h3)) begin
        next_sel = 2'(i);
        has_next = 1'b1;
      end
    end
  end
  assign is_dual = (cfg.mode == `ADCSQ_MODE_CONT) && (nsel == 3'h2);
  assign is_fixed_cont = (cfg.mode == `ADCSQ_MODE_CONT) && (nsel == 3'h1);
  // Fixed continuous and dual modes place by running slot, others by input
  assign store_slot = (is_dual || is_fixed_cont) ? slot_q : chan_q;
  always_comb begin
    unique case (cfg.mode)
      `ADCSQ_MODE_STEP: group_end = 1'b1;
      `ADCSQ_MODE_SINGLE: group_end = !has_next;
      `ADCSQ_MODE_CONT: group_end = (slot_q == `ADCSQ_SLOT_LAST);
      `ADCSQ_MODE_SCANC: group_end = !has_next;
      default: group_end = 1'b1;
    endcase
  end
  assign keep_on = cont_q && !stop_req && cfg.enable;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ADCSQ_IDLE;
      chan_q <= 2'h0;
      slot_q <= 2'h0;
      first_q <= 2'h0;
      run_q <= 1'b0;
      cont_q <= 1'b0;
      sar_start <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      sar_start <= 1'b0;
      if (stop_req || !cfg.enable) begin
        cont_q <= 1'b0;
      end
      unique case (state_q)
        ADCSQ_IDLE: begin
          if (start_req && cfg.enable && cfg.input_sel != 4'h0) begin
            state_q <= ADCSQ_CONV;
            busy_q <= 1'b1;
            sar_start <= 1'b1;
            if (!run_q || cfg.mode != `ADCSQ_MODE_STEP) begin
              chan_q <= first_sel;
            end
            first_q <= first_sel;
            slot_q <= 2'h0;
            run_q <= 1'b1;
            cont_q <= cfg.mode[1];
          end
        end
        ADCSQ_CONV: begin
          if (sar_done) begin
            slot_q <= slot_q + 2'h1;
            if (is_dual) begin
              chan_q <= (chan_q == first_q) ? next_sel : first_q;
            end else if (!is_fixed_cont) begin
              chan_q <= has_next ? next_sel : first_q;
            end
            // Continuous runs end after the current conversion once stopped
            if ((group_end || cfg.mode[1]) && !keep_on) begin
              state_q <= ADCSQ_IDLE;
              busy_q <= 1'b0;
              if (cfg.mode != `ADCSQ_MODE_STEP || !has_next) begin
                run_q <= 1'b0;
              end
            end else begin
              state_q <= ADCSQ_WAIT;
            end
          end
        end
        ADCSQ_WAIT: begin
          state_q <= ADCSQ_CONV;
          sar_start <= 1'b1;
        end
        default: begin
          state_q <= ADCSQ_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      results <= '0;
    end else if (state_q == ADCSQ_CONV && sar_done) begin
      results[store_slot*RES_W +: RES_W] <= sar_result;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_flag <= 1'b0;
    end else if (state_q == ADCSQ_CONV && sar_done && group_end) begin
      done_flag <= 1'b1;
    end else if (done_clr) begin
      done_flag <= 1'b0;
    end
  end
  // Early compare on upper nibble, full compare only if that was inside
  assign early_out =
    (sar_result[RES_W-1:`ADCSQ_MSB_POS] > lim.high[RES_W-1:`ADCSQ_MSB_POS]) ||
    (sar_result[RES_W-1:`ADCSQ_MSB_POS] < lim.low[RES_W-1:`ADCSQ_MSB_POS]);
  assign full_out = (sar_result > lim.high) || (sar_result < lim.low);
  assign bnd_set = cfg.bnd_irq_en && state_q == ADCSQ_CONV &&
                   ((sar_msb_valid && early_out) || (sar_done && early_in_q && full_out));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      early_in_q <= 1'b0;
    end else if (state_q == ADCSQ_CONV && sar_msb_valid) begin
      early_in_q <= !early_out;
    end
  end
  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bnd_flag <= 1'b0;
    end else if (bnd_set) begin
      bnd_flag <= 1'b1;
    end else if (bnd_clr) begin
      bnd_flag <= 1'b0;
    end
  end
  assign sar_chan = chan_q;
  assign busy = busy_q;
endmodule

module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int RES_W = 8
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire adcsq_cfg_t CFG0,
  input wire adcsq_cfg_t CFG1,
  input wire logic START_WR0,
  input wire logic START_WR1,
  input wire adcsq_lim_t LIM0,
  input wire adcsq_lim_t LIM1,
  input wire logic TIMER_OVF,
  input wire logic EDGE_TRIGGER_PIN,
  input wire logic [1:0] DONE_CLR,
  input wire logic [1:0] BND_CLR,
  input wire logic [1:0] SAR_MSB_VALID,
  input wire logic [1:0] SAR_DONE,
  input wire logic [2*RES_W-1:0] SAR_RESULT,
  output logic [1:0] SAR_START,
  output logic [3:0] SAR_CHAN,
  output logic [1:0] BUSY,
  output logic [1:0] CONVERSION_DONE_FLAG,
  output logic [1:0] BOUNDARY_HIT_FLAG,
  output logic [4*RES_W-1:0] RESULTS0,
  output logic [4*RES_W-1:0] RESULTS1
);
  adcsq_cfg_t cfg [2];
  logic [1:0] start_wr;
  logic pin_q;
  logic pin_rise;
  logic pin_fall;
  logic pin_arm_q;
  logic dual_go;
  logic [1:0] start_req;
  logic [1:0] stop_req;
  logic [1:0] busy_w;
  logic [1:0] sar_start_w;
  logic [3:0] chan_w;
  logic [1:0] done_w;
  logic [1:0] bnd_w;
  logic [4*RES_W-1:0] res_w [2];
  assign cfg[0] = CFG0;
  assign cfg[1] = CFG1;
  assign start_wr = {START_WR1, START_WR0};
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      pin_q <= 1'b0;
      pin_arm_q <= 1'b0;
    end else begin
      pin_q <= EDGE_TRIGGER_PIN;
      pin_arm_q <= 1'b1;
    end
  end
  // No edge is seen until the pin has been sampled once after reset
  assign pin_rise = pin_arm_q && EDGE_TRIGGER_PIN && !pin_q;
  assign pin_fall = pin_arm_q && !EDGE_TRIGGER_PIN && pin_q;
  assign dual_go = (START_WR0 && CFG0.start_mode == `ADCSQ_START_DUAL) ||
                   (START_WR1 && CFG1.start_mode == `ADCSQ_START_DUAL);
  for (genvar u = 0; u < 2; u++) begin : g_unit
    always_comb begin
      stop_req[u] = start_wr[u] && cfg[u].start_mode == `ADCSQ_START_STOP &&
                    !cfg[u].timer_sel;
      unique case (cfg[u].start_mode)
        `ADCSQ_START_STOP: start_req[u] = cfg[u].timer_sel && TIMER_OVF;
        `ADCSQ_START_IMM: start_req[u] = start_wr[u];
        `ADCSQ_START_EDGE: start_req[u] = cfg[u].edge_pol ? pin_rise : pin_fall;
        `ADCSQ_START_DUAL: start_req[u] = 1'b0;
        default: start_req[u] = 1'b0;
      endcase
      start_req[u] = start_req[u] || dual_go;
    end
    adcsq_unit #(
      .RES_W(RES_W)
    ) u_unit (
      .clk(SYS_CLK),
      .rst(RESET),
      .cfg(cfg[u]),
      .lim(u == 0 ? LIM0 : LIM1),
      .start_req(start_req[u] && !busy_w[u]),
      .stop_req(stop_req[u]),
      .done_clr(DONE_CLR[u]),
      .bnd_clr(BND_CLR[u]),
      .sar_msb_valid(SAR_MSB_VALID[u]),
      .sar_done(SAR_DONE[u]),
      .sar_result(SAR_RESULT[u*RES_W +: RES_W]),
      .sar_start(sar_start_w[u]),
      .sar_chan(chan_w[u*2 +: 2]),
      .busy(busy_w[u]),
      .done_flag(done_w[u]),
      .bnd_flag(bnd_w[u]),
      .results(res_w[u])
    );
  end
  assign SAR_START = sar_start_w;
  assign SAR_CHAN = chan_w;
  assign BUSY = busy_w;
  assign CONVERSION_DONE_FLAG = done_w;
  assign BOUNDARY_HIT_FLAG = bnd_w;
  assign RESULTS0 = res_w[0];
  assign RESULTS1 = res_w[1];
endmodule
`default_nettype wire

// File: tb/adcsq_sar_model.sv
// Behavioural successive approximation core for both converters
`timescale 1ns/1ps
`default_nettype none
module adcsq_sar_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] start,
  input wire logic [3:0] chan,
  input wire logic [15:0] base,
  input wire logic slow,
  output logic [1:0] msb_valid,
  output logic [1:0] done,
  output logic [15:0] result
);
  logic [4:0] cnt_q [2];
  logic [7:0] val_q [2];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '{5'h00, 5'h00};
      val_q <= '{8'h00, 8'h00};
      msb_valid <= 2'h0;
      done <= 2'h0;
      result <= 16'hA5C3;
    end else begin
      for (int u = 0; u < 2; u++) begin
        msb_valid[u] <= cnt_q[u] == 5'h05;
        done[u] <= cnt_q[u] == 5'h01;
        if (start[u]) begin
          cnt_q[u] <= slow ? 5'h12 : 5'h08;
          val_q[u] <= base[u*8+:8] ^ {4{chan[u*2+:2]}};
        end else if (cnt_q[u] != 5'h00) begin
          cnt_q[u] <= cnt_q[u] - 5'h01;
        end
        // Bits not yet resolved are shown inverted, never held
        result[u*8+:8] <= (cnt_q[u] == 5'h01) ? val_q[u] :
          (cnt_q[u] == 5'h05) ? {val_q[u][7:4], ~val_q[u][3:0]} : ~result[u*8+:8];
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/adcsq_top_sva.sv
// Port checker for the converter sequencer control
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_cfg.svh"
module adcsq_top_sva
  import adcsq_pkg::*;
#(
  parameter int RES_W = 8
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire adcsq_cfg_t CFG0,
  input wire adcsq_cfg_t CFG1,
  input wire logic START_WR0,
  input wire logic START_WR1,
  input wire adcsq_lim_t LIM0,
  input wire logic [1:0] DONE_CLR,
  input wire logic [1:0] SAR_MSB_VALID,
  input wire logic [1:0] SAR_DONE,
  input wire logic [2*RES_W-1:0] SAR_RESULT,
  input wire logic [1:0] SAR_START,
  input wire logic [3:0] SAR_CHAN,
  input wire logic [1:0] BUSY,
  input wire logic [1:0] CONVERSION_DONE_FLAG,
  input wire logic [1:0] BOUNDARY_HIT_FLAG
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  sequence s_imm0;
    START_WR0 && CFG0.enable && CFG0.start_mode == `ADCSQ_START_IMM &&
      CFG0.input_sel != 4'h0 && !BUSY[0];
  endsequence
  sequence s_dual1;
    START_WR1 && CFG1.start_mode == `ADCSQ_START_DUAL && CFG0.enable && CFG1.enable &&
      CFG0.input_sel != 4'h0 && CFG1.input_sel != 4'h0 && BUSY == 2'h0;
  endsequence
  sequence s_step_end;
    SAR_DONE[0] && BUSY[0] && CFG0.mode == `ADCSQ_MODE_STEP;
  endsequence
  AST_IMM_START: assert property (s_imm0 |=> SAR_START[0] && BUSY[0])
    else $error("immediate start not answered");
  AST_DUAL_START: assert property (s_dual1 |=> SAR_START == 2'h3)
    else $error("dual start did not start both");
  AST_BUSY_REFUSE: assert property (SAR_START[0] && $past(BUSY[0]) |-> $past(SAR_DONE[0], 2))
    else $error("start taken while busy");
  AST_CHAN_SEL: assert property (SAR_START[0] |-> CFG0.input_sel[SAR_CHAN[1:0]])
    else $error("unselected channel converted");
  AST_STEP_WAIT: assert property (s_step_end |=> CONVERSION_DONE_FLAG[0] ##[0:1] !BUSY[0])
    else $error("single step did not flag and wait");
  AST_DONE_STICKY: assert property (CONVERSION_DONE_FLAG[0] && !DONE_CLR[0] |=>
    CONVERSION_DONE_FLAG[0])
    else $error("done flag dropped without clear");
  AST_BND_EARLY: assert property (SAR_MSB_VALID[0] && CFG0.bnd_irq_en &&
    (SAR_RESULT[7:4] > LIM0.high[7:4] || SAR_RESULT[7:4] < LIM0.low[7:4]) |=>
    BOUNDARY_HIT_FLAG[0])
    else $error("early limit hit missed");
  AST_BND_FULL: assert property (SAR_DONE[0] && CFG0.bnd_irq_en &&
    (SAR_RESULT[7:0] > LIM0.high || SAR_RESULT[7:0] < LIM0.low) |=> BOUNDARY_HIT_FLAG[0])
    else $error("full limit hit missed");
  AST_BND_MASK: assert property ($rose(BOUNDARY_HIT_FLAG[0]) |-> $past(CFG0.bnd_irq_en))
    else $error("boundary flag set while disabled");
  // Remembers a stop write until converter 0 is idle again
  logic stop_seen_q;
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      stop_seen_q <= 1'b0;
    end else if (START_WR0 && CFG0.start_mode == `ADCSQ_START_STOP && !CFG0.timer_sel) begin
      stop_seen_q <= 1'b1;
    end else if (!BUSY[0]) begin
      stop_seen_q <= 1'b0;
    end
  end
  AST_STOP_END: assert property (SAR_DONE[0] && stop_seen_q |=> !BUSY[0])
    else $error("continuous run went on after stop");
endmodule
`default_nettype wire

// File: tb/adcsq_top_tb.sv
// Self-checking bench for the converter sequencer control
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_cfg.svh"
module adcsq_top_tb;
  import adcsq_pkg::*;
  logic clk = 0, rst = 1, pin = 0, ovf = 0, slow = 0;
  logic [1:0] wr = 0, dclr = 0;
  logic [15:0] base = 0;
  adcsq_cfg_t cfg0 = '0, cfg1 = '0;
  adcsq_lim_t lim0 = '0, lim1 = '0;
  logic [1:0] msbv, sdone, sstart, busy, dflag, bflag;
  logic [3:0] chan;
  logic [15:0] sres;
  logic [31:0] res0, res1, expv;
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 45;
  adcsq_top uut (.SYS_CLK(clk), .RESET(rst), .CFG0(cfg0), .CFG1(cfg1), .START_WR0(wr[0]),
    .START_WR1(wr[1]), .LIM0(lim0), .LIM1(lim1), .TIMER_OVF(ovf), .EDGE_TRIGGER_PIN(pin),
    .DONE_CLR(dclr), .BND_CLR(dclr), .SAR_MSB_VALID(msbv), .SAR_DONE(sdone),
    .SAR_RESULT(sres), .SAR_START(sstart), .SAR_CHAN(chan), .BUSY(busy),
    .CONVERSION_DONE_FLAG(dflag), .BOUNDARY_HIT_FLAG(bflag), .RESULTS0(res0), .RESULTS1(res1));
  adcsq_sar_model sar (.clk(clk), .rst(rst), .start(sstart), .chan(chan), .base(base),
    .slow(slow), .msb_valid(msbv), .done(sdone), .result(sres));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_on(bit fl);
    int k = 0;
    while ((fl ? dflag[0] !== 1'b1 : busy !== 2'h0) && k < 400) begin
      tick();
      k++;
    end
    if (k >= 400) begin
      error_cnt++;
      $display("CHECK FAILED wait %s expected 1 seen 0", fl ? "done" : "idle");
    end
  endtask
  function automatic logic [7:0] rv(int u, logic [1:0] ch);
    return base[u*8+:8] ^ {4{ch}};
  endfunction
  // Expected result bytes: running slots for one or two inputs continuous, else by channel
  function automatic logic [31:0] exp_all(int u, adcsq_cfg_t c);
    logic [1:0] lo = 0;
    logic [1:0] hi = 0;
    logic [31:0] e = 0;
    for (int i = 3; i >= 0; i--) if (c.input_sel[i]) lo = 2'(i);
    for (int i = 0; i < 4; i++) if (c.input_sel[i]) hi = 2'(i);
    for (int n = 0; n < 4; n++) begin
      if (c.mode == `ADCSQ_MODE_CONT && $countones(c.input_sel) <= 2) e[n*8+:8] = rv(u, n[0] ? hi : lo);
      else if (c.input_sel[n]) e[n*8+:8] = rv(u, 2'(n));
    end
    return e;
  endfunction
  function automatic logic bnd_exp(int u, adcsq_cfg_t c);
    logic hit = 0;
    adcsq_lim_t l = u ? lim1 : lim0;
    for (int i = 0; i < 4; i++)
      if (c.input_sel[i] && (rv(u, 2'(i)) > l.high || rv(u, 2'(i)) < l.low)) hit = 1;
    return hit && c.bnd_irq_en;
  endfunction
  task automatic restart(logic [2:0] mode, logic [3:0] sel, logic [1:0] sm);
    rst = 1;
    base = 16'($random(seed));
    lim0 = 16'($random(seed));
    lim1 = 16'($random(seed));
    slow = 1'($random(seed));
    cfg0 = 14'($random(seed));
    cfg0.enable = 1;
    cfg0.mode = mode;
    cfg0.input_sel = sel;
    cfg0.start_mode = sm;
    cfg1 = cfg0;
    tick(4);
    rst = 0;
    tick();
  endtask
  task automatic run(logic [2:0] mode, logic [3:0] sel, logic [1:0] sm);
    restart(mode, sel, sm);
    wr[sm == `ADCSQ_START_DUAL] = 1;
    tick();
    wr = 0;
    wait_on(1);
    chk("results0", exp_all(0, cfg0), res0);
    if (mode[1]) begin
      cfg0.start_mode = `ADCSQ_START_STOP;
      cfg0.timer_sel = 0;
      cfg1 = cfg0;
      wr = 2'h3;
      tick();
      wr = 0;
    end
    wait_on(0);
    chk("busy", 0, busy);
    chk("boundary flag", bnd_exp(0, cfg0), bflag[0]);
    if (sm == `ADCSQ_START_DUAL) chk("results1", exp_all(1, cfg1), res1);
    if (sm == `ADCSQ_START_DUAL) chk("done flag1", 1, dflag[1]);
    if (sm == `ADCSQ_START_DUAL) chk("boundary flag1", bnd_exp(1, cfg1), bflag[1]);
    $display("test mode %h sel %h start %h done", mode, sel, sm);
  endtask
  task automatic fire(logic pol);
    ovf = 1;
    pin = pol;
    tick();
    ovf = 0;
    pin = !pol;
  endtask
  task automatic step(int kind);
    pin = !kind[0];
    restart(`ADCSQ_MODE_STEP, 4'($random(seed)) | 4'h8,
      kind == 2 ? `ADCSQ_START_STOP : `ADCSQ_START_EDGE);
    cfg0.edge_pol = kind[0];
    cfg0.timer_sel = 1;
    expv = 0;
    tick(2);
    for (int i = 0; i < 4; i++) begin
      if (cfg0.input_sel[i]) begin
        fire(cfg0.edge_pol);
        tick(3);
        fire(cfg0.edge_pol);
        wait_on(1);
        expv[i*8+:8] = rv(0, 2'(i));
        chk("step results", expv, res0);
        dclr = 2'h1;
        tick();
        dclr = 0;
        chk("done clear", 0, dflag[0]);
        wait_on(0);
      end
    end
    $display("test step kind %0d done", kind);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    run(`ADCSQ_MODE_SINGLE, 4'h4, `ADCSQ_START_IMM);
    run(`ADCSQ_MODE_SINGLE, 4'hD, `ADCSQ_START_IMM);
    run(`ADCSQ_MODE_SCANC, 4'h6, `ADCSQ_START_IMM);
    run(`ADCSQ_MODE_CONT, 4'h8, `ADCSQ_START_IMM);
    run(`ADCSQ_MODE_CONT, 4'h5, `ADCSQ_START_IMM);
    run(`ADCSQ_MODE_SINGLE, 4'h3, `ADCSQ_START_DUAL);
    for (int k = 0; k < 3; k++) step(k);
    repeat (4) run(`ADCSQ_MODE_SINGLE, 4'($random(seed)) | 4'h1, `ADCSQ_START_IMM);
    test_done();
  end
  initial begin
    #3000000;
    error_cnt++;
    test_done();
  end
endmodule
bind adcsq_top adcsq_top_sva #(.RES_W(RES_W)) u_sva (.SYS_CLK(SYS_CLK), .RESET(RESET),
  .CFG0(CFG0), .CFG1(CFG1), .START_WR0(START_WR0), .START_WR1(START_WR1), .LIM0(LIM0),
  .DONE_CLR(DONE_CLR), .SAR_MSB_VALID(SAR_MSB_VALID), .SAR_DONE(SAR_DONE),
  .SAR_RESULT(SAR_RESULT), .SAR_START(SAR_START), .SAR_CHAN(SAR_CHAN), .BUSY(BUSY),
  .CONVERSION_DONE_FLAG(CONVERSION_DONE_FLAG), .BOUNDARY_HIT_FLAG(BOUNDARY_HIT_FLAG));
`default_nettype wire
